// ==== hdl/sosw_status.sv ====
// Purpose: safety option status word and reset source selection
// Assumes: safety function states come from logic on mclk
// Notes:   host control and selection inputs are synchronised
//
// Overview of operation
// [R1] Source 0: reset accepted only from the control word profile reset.
// [R2] Source 0: an accepted reset also clears the drive alarms.
// [R3] Source 1: host assigns safe reset to a configurable control bit.
// [R4] Source 1: reset leaves drive alarms alone; the bit overrides profile.
// [R5] Status selection 91 shows reset required, 90 shows safe function active.
// [R6] Status word read-only, flags only currently active safe functions.
// [R7] Bit 0 high in normal operation, low on active, pending or warning.
// [R8] Bit 1 set during power-up self-test.
// [R9] Bits 2..6: torque cut-off, stop a, stop b, speed a, speed b.
// [R10] Bits 7..10 reserved, carry no meaning.
// [R11] Bit 11 high while internal failure active.
// [R12] Bit 12 high while a safety option reset is required.
// [R13] Bit 13 pending fail-safe, entered at every power-up.
// [R14] Bit 14 high while external failure active.
// [R15] Bit 15 high while a safe function request is pending.
// [R16] Bits 16..19: reset done, custom confirmed, aborted, requested.
// [R17] Bit 20 speed monitoring suspended, cause in the error code.
// [R18] Bits 21..23: self-test warning, input 1 and input 2 offline warnings.
// [R19] Bits 24..31 hold the 8-bit error code.
// [R20] Status word refreshed every clock as one coherent snapshot.
`timescale 1ns/1ps
module sosw_status
   import sosw_pkg::*;
(
   // clock and reset
   input  wire logic              mclk,
   input  wire logic              rst_n,
   // safety function state
   input  wire logic              power_up_self_test,
   input  wire logic              torque_cutoff,
   input  wire logic              controlled_stop_a,
   input  wire logic              controlled_stop_b,
   input  wire logic              limited_speed_a,
   input  wire logic              limited_speed_b,
   input  wire logic              int_fail_i,
   input  wire logic              ext_fail_i,
   input  wire logic              reset_need_i,
   input  wire logic              failsafe_enter_i,
   input  wire logic              func_pending_i,
   // user and monitoring events
   input  wire logic              general_reset_done_i,
   input  wire logic              custom_confirmed_i,
   input  wire logic              custom_aborted_i,
   input  wire logic              custom_requested_i,
   input  wire logic              speed_mon_suspended_i,
   input  wire logic              self_test_warning_i,
   input  wire logic              input1_offline_test_warning,
   input  wire logic              input2_offline_test_warning,
   input  wire logic [CODE_W-1:0] error_code_i,
   // host side, asynchronous
   input  wire logic              reset_source_i,
   input  wire logic              profile_reset_i,
   input  wire logic              ctw_reset_bit_i,
   input  wire logic [SEL_W-1:0]  stw_select_i,
   // results
   output logic [SOSW_W-1:0]      status_o,
   output logic                   stw_bit_o,
   output logic                   opt_reset_o,
   output logic                   alarm_clear_o
);

   // synchronised host levels
   logic [SYNC_W-1:0] host_s;
   wire               src_s;
   wire               prof_s;
   wire               ctw_s;
   wire [SEL_W-1:0]   sel_s;

   sosw_sync #(
      .W       (SYNC_W)
   ) u_sync (
      .mclk    (mclk),
      .rst_n   (rst_n),
      .async_i ({reset_source_i, profile_reset_i, ctw_reset_bit_i, stw_select_i}),
      .sync_o  (host_s)
   );

   assign src_s  = host_s[SEL_W+2];
   assign prof_s = host_s[SEL_W+1];
   assign ctw_s  = host_s[SEL_W];
   assign sel_s  = host_s[SEL_W-1:0];

   // edge detection on synchronised requests
   logic prof_q;
   logic ctw_q;
   wire  prof_edge;
   wire  ctw_edge;
   wire  accept_d;
   wire  alarm_d;

   assign prof_edge = prof_s & ~prof_q;
   assign ctw_edge  = ctw_s & ~ctw_q;
   // source selects the only legal request path
   assign accept_d  = (src_s == SRC_DRIVE_RESET) ? prof_edge : ctw_edge; // [R1] [R4]
   assign alarm_d   = accept_d & (src_s == SRC_DRIVE_RESET);             // [R2] [R4]

   // pending fail-safe, set at power-up, set wins over clear
   logic pend_fs_q;
   wire  pend_fs_d;

   assign pend_fs_d = failsafe_enter_i | (pend_fs_q & ~accept_d); // [R13]

   // status word assembly
   wire [FUNC_N-1:0] func_act;
   wire [EVT_N-1:0]  evt;
   wire [WARN_N-1:0] warn;
   wire              reset_req;
   wire              any_fn_active;
   wire              normal;
   wire [SOSW_W-1:0] status_d;
   wire              stw_d;

   assign func_act      = {limited_speed_b, limited_speed_a, controlled_stop_b,
                           controlled_stop_a, torque_cutoff};                        // [R9] [R6]
   assign evt           = {custom_requested_i, custom_aborted_i, custom_confirmed_i,
                           general_reset_done_i};                                    // [R16]
   assign warn          = {input2_offline_test_warning, input1_offline_test_warning,
                           self_test_warning_i};                                     // [R18]
   assign reset_req     = reset_need_i | pend_fs_q;                                  // [R12]
   assign any_fn_active = |func_act;
   assign normal        = ~(any_fn_active | power_up_self_test | pend_fs_q | func_pending_i
                            | int_fail_i | ext_fail_i | (|warn));                    // [R7]

   assign status_d[BIT_NORMAL]                = normal;                // [R7]
   assign status_d[BIT_POWER_UP_SELF_TEST]                  = power_up_self_test;    // [R8]
   assign status_d[BIT_FUNC_HI:BIT_FUNC_LO]   = func_act;              // [R9]
   assign status_d[BIT_RSVD_HI:BIT_RSVD_LO]   = 4'h0;                  // [R10]
   assign status_d[BIT_INT_FAIL]              = int_fail_i;            // [R11]
   assign status_d[BIT_RESET_REQ]             = reset_req;             // [R12]
   assign status_d[BIT_PEND_FS]               = pend_fs_q;             // [R13]
   assign status_d[BIT_EXT_FAIL]              = ext_fail_i;            // [R14]
   assign status_d[BIT_FUNC_PEND]             = func_pending_i;        // [R15]
   assign status_d[BIT_EVT_HI:BIT_EVT_LO]     = evt;                   // [R16]
   assign status_d[BIT_SPD_SUSP]              = speed_mon_suspended_i; // [R17]
   assign status_d[BIT_WARN_HI:BIT_WARN_LO]   = warn;                  // [R18]
   assign status_d[BIT_CODE_HI:BIT_CODE_LO]   = error_code_i;          // [R19] [R17]

   // configurable drive status word bit
   assign stw_d = (sel_s == SEL_RESET_REQ)   ? reset_req :
                  (sel_s == SEL_FUNC_ACTIVE) ? any_fn_active : 1'b0;    // [R5]

   // registers, refreshed every clock
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         prof_q        <= 1'b0;
         ctw_q         <= 1'b0;
         pend_fs_q     <= RST_PEND_FS;
         status_o      <= RST_STATUS;
         stw_bit_o     <= 1'b0;
         opt_reset_o   <= 1'b0;
         alarm_clear_o <= 1'b0;
      end else begin
         prof_q        <= prof_s;
         ctw_q         <= ctw_s;
         pend_fs_q     <= pend_fs_d;
         status_o      <= status_d;     // [R20] [R6]
         stw_bit_o     <= stw_d;        // [R5]
         opt_reset_o   <= accept_d;     // [R1] [R4]
         alarm_clear_o <= alarm_d;      // [R2]
      end
   end

   // checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   sequence drive_req_s;
      (src_s == SRC_DRIVE_RESET) && prof_s && !prof_q;
   endsequence

   sequence safe_req_s;
      (src_s == SRC_SAFE_RESET) && ctw_s && !ctw_q;
   endsequence

   sequence reset_no_reenter_s;
      opt_reset_o && !failsafe_enter_i ##1 !failsafe_enter_i;
   endsequence

   drive_src_path_a: assert property (drive_req_s |=> opt_reset_o && alarm_clear_o) // [R1]
      else $error("profile reset not accepted with alarm clear");

   drive_only_a: assert property (opt_reset_o && $past(src_s) == SRC_DRIVE_RESET
                                  |-> $past(prof_s) && !$past(prof_q)) // [R1]
      else $error("reset accepted from wrong path in drive mode");

   alarm_clear_a: assert property (opt_reset_o && $past(src_s) == SRC_DRIVE_RESET
                                   |-> alarm_clear_o) // [R2]
      else $error("drive reset did not clear alarms");

   safe_reset_a: assert property (safe_req_s |=> opt_reset_o && !alarm_clear_o) // [R4]
      else $error("safe reset wrong or cleared drive alarms");

   stw_map_a: assert property (sel_s == SEL_RESET_REQ |=> stw_bit_o == $past(reset_req)) // [R5]
      else $error("status selection does not show reset required");

   bit0_norm_a: assert property (status_o[BIT_NORMAL] == !(|status_o[BIT_INT_FAIL:BIT_POWER_UP_SELF_TEST]
                                 || |status_o[BIT_FUNC_PEND:BIT_PEND_FS]
                                 || |status_o[BIT_WARN_HI:BIT_WARN_LO])) // [R7]
      else $error("normal bit disagrees with state bits");

   safe_only_a: assert property (opt_reset_o && $past(src_s) == SRC_SAFE_RESET
                                 |-> $past(ctw_s) && !$past(ctw_q) && !alarm_clear_o) // [R4]
      else $error("safe mode reset from wrong path or with alarm clear");

   stw_func_a: assert property (sel_s == SEL_FUNC_ACTIVE |=> stw_bit_o == $past(any_fn_active)) // [R5]
      else $error("status selection does not show function active");

   power_up_self_test_bit_a: assert property (status_o[BIT_POWER_UP_SELF_TEST] == $past(power_up_self_test)) // [R8]
      else $error("self-test bit wrong");

   int_fail_a: assert property (status_o[BIT_INT_FAIL] == $past(int_fail_i)) // [R11]
      else $error("internal failure bit wrong");

   reset_req_a: assert property (status_o[BIT_PEND_FS] |-> status_o[BIT_RESET_REQ]) // [R12]
      else $error("pending fail-safe without reset required");

   pend_set_a: assert property (failsafe_enter_i |=> pend_fs_q) // [R13]
      else $error("fail-safe entry not latched");

   ext_fail_a: assert property (status_o[BIT_EXT_FAIL] == $past(ext_fail_i)) // [R14]
      else $error("external failure bit wrong");

   func_pend_a: assert property (status_o[BIT_FUNC_PEND] == $past(func_pending_i)) // [R15]
      else $error("function pending bit wrong");

   event_bits_a: assert property (status_o[BIT_EVT_HI:BIT_EVT_LO] == $past(evt)) // [R16]
      else $error("user event bits wrong");

   susp_bit_a: assert property (status_o[BIT_SPD_SUSP] == $past(speed_mon_suspended_i)) // [R17]
      else $error("suspension bit wrong");

   warn_bits_a: assert property (status_o[BIT_WARN_HI:BIT_WARN_LO] == $past(warn)) // [R18]
      else $error("warning bits wrong");

   func_bits_a: assert property (status_o[BIT_FUNC_HI:BIT_FUNC_LO] == $past(func_act)) // [R9]
      else $error("active function bits wrong");

   rsvd_zero_a: assert property (status_o[BIT_RSVD_HI:BIT_RSVD_LO] == 4'h0) // [R10]
      else $error("reserved bits not zero");

   pend_clear_a: assert property (reset_no_reenter_s |=> !status_o[BIT_PEND_FS]) // [R13]
      else $error("pending fail-safe not cleared by reset");

   err_code_a: assert property (status_o[BIT_CODE_HI:BIT_CODE_LO] == $past(error_code_i)) // [R19]
      else $error("error code field wrong");

endmodule // sosw_status

// ==== hdl/sosw_pkg.sv ====
// Purpose: constants for the safety option status word block
// Assumes: one clock, status word read as a plain 32-bit port
// Notes:   bit positions, field widths, selection codes and reset values only
package sosw_pkg;

   // status word layout
   localparam int SOSW_W            = 32;
   localparam int BIT_NORMAL        = 0;
   localparam int BIT_POWER_UP_SELF_TEST          = 1;
   localparam int BIT_FUNC_LO       = 2;
   localparam int BIT_FUNC_HI       = 6;
   localparam int BIT_RSVD_LO       = 7;
   localparam int BIT_RSVD_HI       = 10;
   localparam int BIT_INT_FAIL      = 11;
   localparam int BIT_RESET_REQ     = 12;
   localparam int BIT_PEND_FS       = 13;
   localparam int BIT_EXT_FAIL      = 14;
   localparam int BIT_FUNC_PEND     = 15;
   localparam int BIT_EVT_LO        = 16;
   localparam int BIT_EVT_HI        = 19;
   localparam int BIT_SPD_SUSP      = 20;
   localparam int BIT_WARN_LO       = 21;
   localparam int BIT_WARN_HI       = 23;
   localparam int BIT_CODE_LO       = 24;
   localparam int BIT_CODE_HI       = 31;

   localparam int FUNC_N            = 5;
   localparam int EVT_N             = 4;
   localparam int WARN_N            = 3;
   localparam int CODE_W            = 8;
   localparam int SEL_W             = 8;

   // reset source selection
   localparam logic SRC_DRIVE_RESET = 1'b0;
   localparam logic SRC_SAFE_RESET  = 1'b1;

   // configurable status word selections
   localparam logic [SEL_W-1:0] SEL_FUNC_ACTIVE = 8'h5a;
   localparam logic [SEL_W-1:0] SEL_RESET_REQ   = 8'h5b;

   // values after reset, and the synchroniser width
   localparam logic              RST_PEND_FS   = 1'b1;
   localparam logic [SOSW_W-1:0] RST_STATUS    = 32'h0000_3000;
   localparam int                SYNC_W        = SEL_W + 3;

endpackage

// ==== hdl/sosw_sync.sv ====
// Purpose: two-stage synchroniser for host-side levels
// Assumes: inputs are levels that hold for several clocks
// Notes:   first stage is read only by the second
`timescale 1ns/1ps
module sosw_sync #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         mclk,
   input  wire logic         rst_n,
   // levels
   input  wire logic [W-1:0] async_i,
   output logic      [W-1:0] sync_o
);

   logic [W-1:0] meta_q;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= '0;
         sync_o <= '0;
      end else begin
         meta_q <= async_i;
         sync_o <= meta_q;
      end
   end

endmodule // sosw_sync

// ==== tb/sosw_host.sv ====
// Purpose: host drive model facing the status block
// Assumes: host levels change just after the mclk rising edge
// Notes:   safe reset rides a configurable control bit
`timescale 1ns/1ps
module sosw_host
   import sosw_pkg::*;
(
   // clock and block results
   input  wire logic        mclk,
   input  wire logic        opt_reset_o,
   input  wire logic        alarm_clear_o,
   // host levels
   output logic             reset_source_i,
   output logic [SEL_W-1:0] stw_select_i,
   output logic             profile_reset_i,
   output logic             ctw_reset_bit_i
);
   initial begin
      reset_source_i  = SRC_DRIVE_RESET;
      stw_select_i    = 8'h00;
      profile_reset_i = 1'b0;
      ctw_reset_bit_i = 1'b0;
   end
   // hold one request line high, count accepted resets and alarm clears
   task automatic req(input logic drive_control_word, output int pulses, output int clears);
      pulses = 0;
      clears = 0;
      @(posedge mclk);
      if (drive_control_word) ctw_reset_bit_i <= 1'b1;
      else profile_reset_i <= 1'b1;
      repeat (8) begin
         @(negedge mclk);
         if (opt_reset_o === 1'b1) pulses++;
         if (alarm_clear_o === 1'b1) clears++;
      end
      @(posedge mclk);
      ctw_reset_bit_i <= 1'b0;
      profile_reset_i <= 1'b0;
      repeat (4) @(posedge mclk);
   endtask
endmodule // sosw_host

// ==== tb/sosw_status_bench.sv ====
// Purpose: self-checking bench for the status word block
// Assumes: status follows inputs one clock later
// Notes:   sv index equals the status bit it feeds
`timescale 1ns/1ps
module sosw_status_bench;
   import sosw_pkg::*;
   logic              mclk = 1'b0;
   logic              rst_n = 1'b0;
   logic [23:0]       sv = '0;
   logic [CODE_W-1:0] code = '0;
   logic [SOSW_W-1:0] status_o;
   logic              stw_bit_o, opt_reset_o, alarm_clear_o, rsrc, prst, ctwb;
   logic [SEL_W-1:0]  sel;
   int                err_total = 0, cmp_count = 0, cyc = 0, np, nc;
   always #20 mclk = ~mclk;
   sosw_status u_sosw_status (.mclk(mclk), .rst_n(rst_n), .power_up_self_test(sv[1]),
      .torque_cutoff(sv[2]), .controlled_stop_a(sv[3]), .controlled_stop_b(sv[4]),
      .limited_speed_a(sv[5]), .limited_speed_b(sv[6]), .int_fail_i(sv[11]),
      .ext_fail_i(sv[14]), .reset_need_i(sv[12]), .failsafe_enter_i(sv[13]),
      .func_pending_i(sv[15]), .general_reset_done_i(sv[16]), .custom_confirmed_i(sv[17]),
      .custom_aborted_i(sv[18]), .custom_requested_i(sv[19]), .speed_mon_suspended_i(sv[20]),
      .self_test_warning_i(sv[21]), .input1_offline_test_warning(sv[22]),
      .input2_offline_test_warning(sv[23]), .error_code_i(code), .reset_source_i(rsrc),
      .profile_reset_i(prst), .ctw_reset_bit_i(ctwb), .stw_select_i(sel),
      .status_o(status_o), .stw_bit_o(stw_bit_o), .opt_reset_o(opt_reset_o),
      .alarm_clear_o(alarm_clear_o));
   sosw_host u_sosw_host (.mclk(mclk), .opt_reset_o(opt_reset_o), .alarm_clear_o(alarm_clear_o),
      .reset_source_i(rsrc), .stw_select_i(sel), .profile_reset_i(prst), .ctw_reset_bit_i(ctwb));
   task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wt(int n);
      repeat (n) @(posedge mclk);
      @(negedge mclk);
   endtask
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // pend and reset required after power-up, cleared by a profile reset
   task automatic t_drive_reset();
      wt(2);
      chk("power-up bits", 32'h0000_3000, status_o);
      u_sosw_host.req(1'b1, np, nc);
      chk("ctw reset in drive mode", 32'h0, np);
      u_sosw_host.req(1'b0, np, nc);
      chk("profile reset pulses", 32'h1, np);
      chk("alarm clears", 32'h1, nc);
      wt(0);
      chk("status after reset", 32'h1, status_o);
   endtask
   // second power-up in mid-run re-enters pending fail-safe
   task automatic t_rereset();
      @(posedge mclk);
      rst_n <= 1'b0;
      sv <= '0;
      wt(2);
      chk("reset word again", RST_STATUS, status_o);
      @(posedge mclk);
      rst_n <= 1'b1;
      wt(2);
      chk("second power-up bits", 32'h0000_3000, status_o);
   endtask
   // safe mode: only the control bit resets, alarms kept
   task automatic t_safe_reset();
      @(posedge mclk);
      u_sosw_host.reset_source_i <= SRC_SAFE_RESET;
      sv[13] <= 1'b1;
      @(posedge mclk);
      sv[13] <= 1'b0;
      wt(4);
      chk("fail-safe entered", 32'h0000_3000, status_o);
      u_sosw_host.req(1'b0, np, nc);
      chk("profile reset in safe mode", 32'h0, np);
      u_sosw_host.req(1'b1, np, nc);
      chk("ctw reset pulses", 32'h1, np);
      chk("alarm clears safe", 32'h0, nc);
      wt(0);
      chk("status after safe reset", 32'h1, status_o);
   endtask
   // every input bit except 13 alone, then all except 13 together as one snapshot
   task automatic t_bits();
      logic [31:0] exp;
      for (int b = 1; b < 24; b++) begin
         if ((b > 6 && b < 11) || b == 13) continue;
         @(posedge mclk);
         sv[b] <= 1'b1;
         wt(1);
         exp = (32'h1 << b) | ((32'h001f_1000 >> b) & 32'h1);
         chk("single bit", exp, status_o);
         @(posedge mclk);
         sv[b] <= 1'b0;
      end
      @(posedge mclk);
      sv <= 24'hffdf_ff;
      code <= 8'ha5;
      wt(1);
      chk("snapshot", 32'ha5ff_d87e, status_o);
      @(posedge mclk);
      sv <= '0;
      code <= '0;
      wt(1);
      chk("cleared", 32'h1, status_o);
   endtask
   // configurable status bit selections
   task automatic t_stw();
      @(posedge mclk);
      u_sosw_host.stw_select_i <= SEL_RESET_REQ;
      sv[12] <= 1'b1;
      wt(4);
      chk("stw reset required", 32'h1, stw_bit_o);
      @(posedge mclk);
      sv[12] <= 1'b0;
      wt(4);
      chk("stw reset idle", 32'h0, stw_bit_o);
      @(posedge mclk);
      u_sosw_host.stw_select_i <= SEL_FUNC_ACTIVE;
      sv[2] <= 1'b1;
      wt(4);
      chk("stw function active", 32'h1, stw_bit_o);
      @(posedge mclk);
      u_sosw_host.stw_select_i <= 8'h5c;
      wt(4);
      chk("stw other selection", 32'h0, stw_bit_o);
   endtask
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 2000) begin
         err_total++;
         conclude();
      end
   end
   initial begin
      repeat (12) @(posedge mclk);
      chk("reset word", RST_STATUS, status_o);
      rst_n <= 1'b1;
      t_drive_reset();
      t_safe_reset();
      t_bits();
      t_stw();
      t_rereset();
      conclude();
   end
endmodule // sosw_status_bench
